/* hdl/rgm_mux.sv */
// relocatable gpio function mux top
`timescale 1ns/1ps
module rgm_mux #(
    parameter int NUM_PINS = rgm_pkg::NUM_PINS
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic cfg_load,
    input wire logic [rgm_pkg::NUM_FUNCS*rgm_pkg::SEL_W-1:0] cfg_func_pin,
    input wire logic [2*NUM_PINS-1:0] cfg_pin_mode,
    input wire logic [NUM_PINS-1:0] gpio_out,
    input wire logic [NUM_PINS-1:0] gpio_oe,
    input wire logic [NUM_PINS-1:0] spec_out,
    input wire logic [NUM_PINS-1:0] spec_oe,
    input wire rgm_pkg::rgm_func_out_t func_out,
    input wire logic [NUM_PINS-1:0] pin_in,
    output logic [NUM_PINS-1:0] pin_out,
    output logic [NUM_PINS-1:0] pin_oe,
    output logic [NUM_PINS-1:0] gpio_in,
    output rgm_pkg::rgm_func_in_t func_in
);
    logic [rgm_pkg::SEL_W-1:0] sel [rgm_pkg::NUM_FUNCS];
    logic [1:0] mode [NUM_PINS];
    logic [NUM_PINS-1:0] sync1;
    logic [NUM_PINS-1:0] sync2;
    logic [rgm_pkg::NUM_FUNCS-1:0] fdrv;

    always_ff @(posedge clk_sys)
    begin
        for (int f = 0; f < rgm_pkg::NUM_FUNCS; f++)
        begin
            if (rst)
                sel[f] <= rgm_pkg::DEF_PIN[f];
            else if (cfg_load)
                sel[f] <= cfg_func_pin[f*rgm_pkg::SEL_W +: rgm_pkg::SEL_W];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        for (int p = 0; p < NUM_PINS; p++)
        begin
            if (rst)
                mode[p] <= rgm_pkg::MODE_GPIO;
            else if (cfg_load)
                mode[p] <= cfg_pin_mode[2*p +: 2];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        sync1 <= pin_in;
        sync2 <= sync1;
    end

    // drive level per function; relays use active-low levels
    always_comb
    begin
        fdrv = '1;
        fdrv[rgm_pkg::FN_MEM_IO] = func_out.mem_serial_out;
        fdrv[rgm_pkg::FN_MEM_CS] = func_out.mem_select_n;
        fdrv[rgm_pkg::FN_MEM_SK] = func_out.mem_shift_clk;
        fdrv[rgm_pkg::FN_HOOK] = func_out.line_hook_relay_n;
        fdrv[rgm_pkg::FN_VOICE] = func_out.voice_relay_n;
        fdrv[rgm_pkg::FN_CALLER] = func_out.caller_info_relay_n;
        fdrv[rgm_pkg::FN_VDATA] = func_out.voice_data_relay_n;
        fdrv[rgm_pkg::FN_SPKSEL] = func_out.speaker_headset_sel;
        fdrv[rgm_pkg::FN_PULSE] = func_out.pulse_dial_n;
        fdrv[rgm_pkg::FN_TINKLE] = func_out.tinkle_suppress_n;
    end

    genvar gp;
    generate
        for (gp = 0; gp < NUM_PINS; gp++)
        begin : g_pin
            logic hit;
            logic drv;
            logic oe;
            // lowest function code owns a contested pin
            always_comb
            begin
                hit = 1'b0;
                drv = 1'b1;
                oe = 1'b0;
                for (int f = rgm_pkg::NUM_FUNCS - 1; f >= 0; f--)
                begin
                    if (sel[f] == rgm_pkg::SEL_W'(gp))
                    begin
                        hit = 1'b1;
                        drv = fdrv[f];
                        if (f == int'(rgm_pkg::FN_LPHONE))
                            oe = 1'b0;
                        else if (f == int'(rgm_pkg::FN_MEM_IO))
                            oe = func_out.mem_serial_oe;
                        else
                            oe = 1'b1;
                    end
                end
            end
            rgm_pin_slice u_slice (
                .clk_sys(clk_sys),
                .rst(rst),
                .mode(mode[gp]),
                .func_hit(hit),
                .func_drv(drv),
                .func_oe(oe),
                .gpio_out(gpio_out[gp]),
                .gpio_oe(gpio_oe[gp]),
                .spec_out(spec_out[gp]),
                .spec_oe(spec_oe[gp]),
                .pin_out(pin_out[gp]),
                .pin_oe(pin_oe[gp])
            );
        end
    endgenerate

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            gpio_in <= '0;
            func_in <= '{mem_serial_in: 1'b0, local_phone_on_hook: 1'b1};
        end
        else
        begin
            gpio_in <= sync2;
            func_in.mem_serial_in <= (sel[rgm_pkg::FN_MEM_IO] < rgm_pkg::SEL_W'(NUM_PINS))
                ? sync2[sel[rgm_pkg::FN_MEM_IO]] : 1'b0;
            func_in.local_phone_on_hook <= (sel[rgm_pkg::FN_LPHONE] < rgm_pkg::SEL_W'(NUM_PINS))
                ? sync2[sel[rgm_pkg::FN_LPHONE]] : 1'b1;
        end
    end

    property p_reset_relay;
        @(posedge clk_sys) rst |=> (pin_out == '1) && (pin_oe == '0);
    endproperty
    a_reset_relay: assert property (p_reset_relay) else $error("pins not idle after reset");

    property p_hook;
        @(posedge clk_sys) disable iff (rst)
        (sel[rgm_pkg::FN_HOOK] == 5'h03) && (sel[rgm_pkg::FN_MEM_IO] != 5'h03)
        && (sel[rgm_pkg::FN_MEM_CS] != 5'h03) && (sel[rgm_pkg::FN_MEM_SK] != 5'h03)
        |=> pin_oe[3] && (pin_out[3] == $past(func_out.line_hook_relay_n));
    endproperty
    a_hook: assert property (p_hook) else $error("hook relay pin wrong");

    property p_detect;
        @(posedge clk_sys) disable iff (rst)
        (sel[rgm_pkg::FN_LPHONE] == 5'h07) && (sel[rgm_pkg::FN_MEM_IO] != 5'h07)
        && (sel[rgm_pkg::FN_MEM_CS] != 5'h07) && (sel[rgm_pkg::FN_MEM_SK] != 5'h07)
        && (sel[rgm_pkg::FN_HOOK] != 5'h07) && (sel[rgm_pkg::FN_VOICE] != 5'h07)
        && (sel[rgm_pkg::FN_CALLER] != 5'h07) && (sel[rgm_pkg::FN_VDATA] != 5'h07)
        |=> !pin_oe[7];
    endproperty
    a_detect: assert property (p_detect) else $error("detect pin driven");

    logic [rgm_pkg::SEL_W-1:0] cfg_hook_pin;
    assign cfg_hook_pin = cfg_func_pin[rgm_pkg::FN_HOOK*rgm_pkg::SEL_W +: rgm_pkg::SEL_W];
    sequence s_cfg_taken;
        !rst && cfg_load;
    endsequence
    property p_cfg_take;
        @(posedge clk_sys) disable iff (rst)
        s_cfg_taken |=> sel[rgm_pkg::FN_HOOK] == $past(cfg_hook_pin);
    endproperty
    a_cfg_take: assert property (p_cfg_take) else $error("relocation not taken");

    property p_gpio_sync;
        @(posedge clk_sys) disable iff (rst)
        !rst |=> gpio_in == $past(pin_in, 3);
    endproperty
    a_gpio_sync: assert property (p_gpio_sync) else $error("gpio input wrong");

    sequence s_mem_io_home;
        sel[rgm_pkg::FN_MEM_IO] == 5'h00;
    endsequence
    property p_mem_oe;
        @(posedge clk_sys) disable iff (rst)
        s_mem_io_home |=> pin_oe[0] == $past(func_out.mem_serial_oe);
    endproperty
    a_mem_oe: assert property (p_mem_oe) else $error("memory data enable wrong");

    property p_detect_level;
        @(posedge clk_sys) disable iff (rst)
        sel[rgm_pkg::FN_LPHONE] == 5'h07 |=> func_in.local_phone_on_hook == $past(pin_in[7], 3);
    endproperty
    a_detect_level: assert property (p_detect_level) else $error("detect level wrong");

    sequence s_caller_home;
        (sel[rgm_pkg::FN_CALLER] == 5'h05) && (sel[rgm_pkg::FN_MEM_IO] != 5'h05)
        && (sel[rgm_pkg::FN_MEM_CS] != 5'h05) && (sel[rgm_pkg::FN_MEM_SK] != 5'h05)
        && (sel[rgm_pkg::FN_HOOK] != 5'h05) && (sel[rgm_pkg::FN_VOICE] != 5'h05);
    endsequence
    property p_caller;
        @(posedge clk_sys) disable iff (rst)
        s_caller_home |=> pin_oe[5] && (pin_out[5] == $past(func_out.caller_info_relay_n));
    endproperty
    a_caller: assert property (p_caller) else $error("caller relay pin wrong");
endmodule : rgm_mux

/* include/rgm_pkg.sv */
// package for the relocatable gpio function mux
// Operation
// - 24 pins: gpio, special, or pin-function
// - any pin-function routable to any pin
// - memory port uses clock, select, data
// - default map pins zero through ten
// - memory data pin drives and samples
// - memory select is an output
// - hook relay output active low
// - caller relay active low, high at power-up
// - voice/data relay output active low
// - local phone detect high means on-hook
// - speaker select high external, low headset
// - pulse dial output active low
// - tinkle suppress output active low
package rgm_pkg;
    localparam int NUM_PINS = 24;
    localparam int SEL_W = 5;
    localparam int NUM_FUNCS = 11;
    // function codes; a pin selection at or above NUM_PINS routes that function to no pin
    localparam logic [3:0] FN_MEM_IO = 4'h0;
    localparam logic [3:0] FN_MEM_CS = 4'h1;
    localparam logic [3:0] FN_MEM_SK = 4'h2;
    localparam logic [3:0] FN_HOOK = 4'h3;
    localparam logic [3:0] FN_VOICE = 4'h4;
    localparam logic [3:0] FN_CALLER = 4'h5;
    localparam logic [3:0] FN_VDATA = 4'h6;
    localparam logic [3:0] FN_LPHONE = 4'h7;
    localparam logic [3:0] FN_SPKSEL = 4'h8;
    localparam logic [3:0] FN_PULSE = 4'h9;
    localparam logic [3:0] FN_TINKLE = 4'hA;
    // reset pin selection per function, indexed by function code
    localparam logic [SEL_W-1:0] DEF_PIN [NUM_FUNCS] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04,
        5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A};
    // per-pin special function mode
    localparam logic [1:0] MODE_GPIO = 2'h0;
    localparam logic [1:0] MODE_SPECIAL = 2'h1;
    typedef struct packed {
        logic mem_select_n;
        logic mem_shift_clk;
        logic mem_serial_out;
        logic mem_serial_oe;
        logic line_hook_relay_n;
        logic voice_relay_n;
        logic caller_info_relay_n;
        logic voice_data_relay_n;
        logic speaker_headset_sel;
        logic pulse_dial_n;
        logic tinkle_suppress_n;
    } rgm_func_out_t;
    typedef struct packed {
        logic mem_serial_in;
        logic local_phone_on_hook;
    } rgm_func_in_t;
endpackage : rgm_pkg

/* hdl/rgm_pin_slice.sv */
// one pin output stage: select among gpio, special and pin-function
`timescale 1ns/1ps
module rgm_pin_slice (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [1:0] mode,
    input wire logic func_hit,
    input wire logic func_drv,
    input wire logic func_oe,
    input wire logic gpio_out,
    input wire logic gpio_oe,
    input wire logic spec_out,
    input wire logic spec_oe,
    output logic pin_out,
    output logic pin_oe
);
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pin_out <= 1'b1;
            pin_oe <= 1'b0;
        end
        else if (func_hit)
        begin
            pin_out <= func_drv;
            pin_oe <= func_oe;
        end
        else if (mode == rgm_pkg::MODE_SPECIAL)
        begin
            pin_out <= spec_out;
            pin_oe <= spec_oe;
        end
        else
        begin
            pin_out <= gpio_out;
            pin_oe <= gpio_oe;
        end
    end
endmodule : rgm_pin_slice

/* verification/rgm_far_model.sv */
// far side: serial memory data, local phone switch, pull-ups
`timescale 1ns/1ps
module rgm_far_model (
    input wire logic [23:0] pin_out,
    input wire logic [23:0] pin_oe,
    input wire logic [4:0] io_pin,
    input wire logic [4:0] lp_pin,
    input wire logic mem_do,
    input wire logic on_hook,
    output logic [23:0] pin_in
);
    always_comb
    begin
        for (int i = 0; i < 24; i++)
        begin
            // memory and phone drive released pins
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (i == io_pin)
                pin_in[i] = mem_do;
            else if (i == lp_pin)
                pin_in[i] = on_hook;
            else
                pin_in[i] = 1'h1;
        end
    end
endmodule : rgm_far_model

/* verification/relocatable_gpio_function_mux_test.sv */
// self-checking bench for the pin function mux
`timescale 1ns/1ps
module relocatable_gpio_function_mux_test;
    logic clk_sys = 1'h0;
    logic rst = 1'h1;
    logic cfg_load = 1'h0;
    logic [54:0] cfg_func_pin;
    logic [47:0] cfg_pin_mode = '0;
    logic [23:0] gpio_out = '0, gpio_oe = '0, spec_out = '0, spec_oe = '0;
    rgm_pkg::rgm_func_out_t func_out = '1;
    rgm_pkg::rgm_func_in_t func_in;
    logic [23:0] pin_in, pin_out, pin_oe, gpio_in, e_out, e_oe, e_lvl;
    logic [4:0] sel [11];
    logic mem_do = 1'h0, on_hook = 1'h1;
    int n_errors = 0, tests_run = 0;
    always #12.5 clk_sys = ~clk_sys;
    always_comb
        for (int f = 0; f < 11; f++)
            cfg_func_pin[5*f+:5] = sel[f];
    rgm_mux dut (.clk_sys(clk_sys), .rst(rst), .cfg_load(cfg_load),
        .cfg_func_pin(cfg_func_pin), .cfg_pin_mode(cfg_pin_mode), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .spec_out(spec_out), .spec_oe(spec_oe), .func_out(func_out),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .gpio_in(gpio_in),
        .func_in(func_in));
    rgm_far_model far (.pin_out(pin_out), .pin_oe(pin_oe), .io_pin(sel[0]),
        .lp_pin(sel[7]), .mem_do(mem_do), .on_hook(on_hook), .pin_in(pin_in));
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    function automatic void predict();
        logic [10:0] v;
        logic [3:0] f;
        logic hit;
        v = {func_out.mem_serial_out, func_out.mem_select_n, func_out.mem_shift_clk,
            func_out.line_hook_relay_n, func_out.voice_relay_n, func_out.caller_info_relay_n,
            func_out.voice_data_relay_n, 1'h1, func_out.speaker_headset_sel,
            func_out.pulse_dial_n, func_out.tinkle_suppress_n};
        for (int p = 0; p < 24; p++)
        begin
            hit = 1'h0;
            f = 4'h0;
            for (int k = 10; k >= 0; k--)
                if (sel[k] == p)
                begin
                    hit = 1'h1;
                    f = k[3:0];
                end
            // detect pin is read only, data pin follows its enable
            if (hit)
                {e_out[p], e_oe[p]} = {v[10-f], f == rgm_pkg::FN_MEM_IO ?
                    func_out.mem_serial_oe : f != rgm_pkg::FN_LPHONE};
            else if (cfg_pin_mode[2*p+:2] == rgm_pkg::MODE_SPECIAL)
                {e_out[p], e_oe[p]} = {spec_out[p], spec_oe[p]};
            else
                {e_out[p], e_oe[p]} = {gpio_out[p], gpio_oe[p]};
            e_lvl[p] = e_oe[p] ? e_out[p] : p == sel[0] ? mem_do : p == sel[7] ? on_hook : 1'h1;
        end
    endfunction : predict
    task automatic step(input bit load, input bit rnd);
        @(posedge clk_sys);
        #2;
        {gpio_out, gpio_oe} = {24'($urandom), 24'($urandom)};
        {spec_out, spec_oe} = {24'($urandom), 24'($urandom)};
        func_out = rgm_pkg::rgm_func_out_t'(11'($urandom));
        {mem_do, on_hook} = 2'($urandom);
        if (load)
        begin
            if (rnd)
            begin
                for (int f = 0; f < 11; f++)
                    sel[f] = 5'($urandom_range(0, 27));
                cfg_pin_mode = {16'($urandom), $urandom};
            end
            cfg_load = 1'h1;
            @(posedge clk_sys);
            #2;
            cfg_load = 1'h0;
        end
        repeat (7) @(posedge clk_sys);
        #2;
        predict();
        check(pin_oe, e_oe);
        check(pin_out & e_oe, e_out & e_oe);
        check(gpio_in, e_lvl);
        if (sel[0] < 24)
            check(func_in.mem_serial_in, e_lvl[sel[0]]);
        if (sel[7] < 24 && !(e_oe[sel[7]] || sel[0] == sel[7]))
            check(func_in.local_phone_on_hook, e_lvl[sel[7]]);
    endtask : step
    task automatic do_reset();
        rst = 1'h1;
        cfg_pin_mode = '0;
        for (int f = 0; f < 11; f++)
            sel[f] = 5'(f);
        repeat (10) @(posedge clk_sys);
        #2;
        check(pin_out, '1);
        check(pin_oe, '0);
        check(func_in.local_phone_on_hook, 1'h1);
        check(gpio_in, '0);
        check(func_in.mem_serial_in, 1'h0);
        rst = 1'h0;
    endtask : do_reset
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    initial
    begin
        #75000;
        n_errors++;
        stop_test();
    end
    initial
    begin
        void'($urandom(32'h3A90));
        do_reset();
        // default map without any load
        repeat (4) step(1'h0, 1'h0);
        check(pin_oe[10:1], 10'h3BF);
        $display("test defaults done");
        // hook and speaker contest pin 23, memory port moved up
        sel[3] = 5'h17;
        sel[8] = 5'h17;
        sel[10] = 5'h18;
        {sel[0], sel[1], sel[2]} = {5'h14, 5'h15, 5'h16};
        step(1'h1, 1'h0);
        check(pin_out[23], func_out.line_hook_relay_n);
        check({pin_oe[22:21], pin_oe[23]}, 3'h7);
        check(pin_out[22:21], {func_out.mem_shift_clk, func_out.mem_select_n});
        check(pin_oe[20], func_out.mem_serial_oe);
        $display("test relocate done");
        repeat (60) step(1'h1, 1'h1);
        $display("test random done");
        do_reset();
        step(1'h0, 1'h0);
        $display("test reset done");
        stop_test();
    end
endmodule : relocatable_gpio_function_mux_test
